// ---- logic/btc_pkg.sv ----
/*
  Shared constants and types for the bit-test / call / clear execution block.
  Assumes a 12-bit instruction word, an 11-bit program counter and 8-bit data.
*/
`default_nettype none
package btc_pkg;

  localparam int INSTR_W  = 12;
  localparam int PC_W     = 11;
  localparam int DATA_W   = 8;
  localparam int FADDR_W  = 5;
  localparam int BSEL_W   = 3;
  localparam int LIT_W    = 8;
  localparam int PAGE_W   = 2;
  localparam int WDT_W    = 8;
  localparam int CNT_W    = 8;

  // opcode fields
  localparam logic [INSTR_W-1:0] OPC_CLEAR_ACC  = 12'h040;
  localparam logic [INSTR_W-1:0] OPC_WDOG_CLEAR = 12'h004;
  localparam logic [3:0]         OPC_BT_CLEAR   = 4'h6;
  localparam logic [3:0]         OPC_BT_SET     = 4'h7;
  localparam logic [3:0]         OPC_CALL       = 4'h9;
  localparam logic [6:0]         OPC_CLEAR_FILE = 7'h03;

  // program counter layout for the call target
  localparam int PC_LIT_HI  = 7;
  localparam int PC_BIT8    = 8;
  localparam int STAT_PG_HI = 6;
  localparam int STAT_PG_LO = 5;

  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  localparam logic [WDT_W-1:0]  WDT_CLEAR  = 8'h00;
  localparam logic [PC_W-1:0]   PC_STEP    = 11'h001;

  // Avalon-MM register map, byte addresses
  localparam int AV_ADDR_W = 4;
  localparam int AV_DATA_W = 32;
  localparam logic [AV_ADDR_W-1:0] OFS_CTRL  = 4'h0;
  localparam logic [AV_ADDR_W-1:0] OFS_STATE = 4'h4;
  localparam logic [AV_ADDR_W-1:0] OFS_SKIPS = 4'h8;

  // control register fields
  localparam int CTRL_PSA_WDOG = 0;
  localparam int CTRL_EXEC_EN  = 1;
  localparam int CTRL_W        = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h3;

  // state register fields
  localparam int ST_FLUSH   = 0;
  localparam int ST_LASTSKP = 1;
  localparam int ST_ZERO    = 2;
  localparam int ST_TO_N    = 3;
  localparam int ST_PD_N    = 4;
  localparam int ST_W       = 5;

  typedef enum logic [2:0] {
    K_OTHER, K_BT_CLEAR, K_BT_SET, K_CLEAR_ACC, K_CLEAR_FILE, K_CALL, K_WDOG_CLEAR
  } btc_kind_t;

  typedef struct packed {
    btc_kind_t            kind;
    logic [FADDR_W-1:0]   faddr;
    logic [BSEL_W-1:0]    bsel;
    logic [LIT_W-1:0]     lit;
  } btc_op_t;

  typedef struct packed {
    logic                 valid;
    logic [INSTR_W-1:0]   word;
    logic [PC_W-1:0]      pc;
    logic [DATA_W-1:0]    fdata;
    logic [DATA_W-1:0]    status;
  } btc_instr_t;

endpackage : btc_pkg
`default_nettype wire

// ---- logic/btc_decode.sv ----
/*
  Instruction decoder: classifies a word into one of the handled operations.
  Assumes the word is stable in the cycle it is presented; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module btc_decode (
  input  wire logic [btc_pkg::INSTR_W-1:0] word,
  output var  btc_pkg::btc_op_t            op
);

  function automatic btc_pkg::btc_kind_t kind_of(input logic [btc_pkg::INSTR_W-1:0] w);
    if (w == btc_pkg::OPC_CLEAR_ACC)        kind_of = btc_pkg::K_CLEAR_ACC;
    else if (w == btc_pkg::OPC_WDOG_CLEAR)  kind_of = btc_pkg::K_WDOG_CLEAR;
    else if (w[11:8] == btc_pkg::OPC_BT_CLEAR) kind_of = btc_pkg::K_BT_CLEAR;
    else if (w[11:8] == btc_pkg::OPC_BT_SET)   kind_of = btc_pkg::K_BT_SET;
    else if (w[11:8] == btc_pkg::OPC_CALL)     kind_of = btc_pkg::K_CALL;
    else if (w[11:5] == btc_pkg::OPC_CLEAR_FILE) kind_of = btc_pkg::K_CLEAR_FILE;
    else                                    kind_of = btc_pkg::K_OTHER;
  endfunction : kind_of

  always_comb begin
    op.kind  = kind_of(word);
    op.faddr = word[btc_pkg::FADDR_W-1:0];
    op.bsel  = word[7:5];
    op.lit   = word[btc_pkg::LIT_W-1:0];
  end

endmodule : btc_decode
`default_nettype wire

// ---- logic/btc_flow.sv ----
/*
  Instruction flow tracker: after a taken skip or a call, the next presented
  instruction (already prefetched) is discarded and a no-op runs instead.
  Assumes one instruction may be presented per enabled cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module btc_flow (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic take,
  input  wire logic two_cycle,
  output logic      discard
);

  typedef enum logic [1:0] {
    FL_RUN   = 2'b00,
    FL_FLUSH = 2'b01
  } btc_flow_t;

  btc_flow_t state_r;
  btc_flow_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FL_RUN: begin
        if (take && two_cycle) state_nxt = FL_FLUSH;
      end
      FL_FLUSH: begin
        if (take) state_nxt = FL_RUN;
      end
      default: state_nxt = FL_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= FL_RUN;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign discard = (state_r == FL_FLUSH);

endmodule : btc_flow
`default_nettype wire

// ---- logic/btc_exec.sv ----
/*
  Execution unit for bit test and skip, clear accumulator, clear file
  register, subroutine call and watchdog clear, with an Avalon-MM slave for
  control and observation. Assumes fetch presents each instruction together
  with its program counter, the addressed file register's value and the
  status register, all on this clock; results leave as registered strobes.
*/
`timescale 1ns/1ns
`default_nettype none
module btc_exec (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // instruction side
  input  wire btc_pkg::btc_instr_t          instr,
  output logic                              discard,
  // file register write
  output logic                              file_we,
  output logic [btc_pkg::FADDR_W-1:0]       file_waddr,
  output logic [btc_pkg::DATA_W-1:0]        file_wdata,
  // accumulator write
  output logic                              acc_we,
  output logic [btc_pkg::DATA_W-1:0]        acc_wdata,
  // status updates
  output logic                              zero_we,
  output logic                              zero_val,
  output logic                              timeout_status_n_we,
  output logic                              power_down_status_n_we,
  output logic                              status_n_val,
  // program flow
  output logic                              pc_load,
  output logic [btc_pkg::PC_W-1:0]          pc_target,
  output logic                              stack_push,
  output logic [btc_pkg::PC_W-1:0]          stack_data,
  output logic                              nop_exec,
  // watchdog and prescaler
  output logic                              watchdog_counter_load,
  output logic [btc_pkg::WDT_W-1:0]         watchdog_counter_value,
  output logic                              prescaler_clear,
  // Avalon-MM slave
  input  wire logic [btc_pkg::AV_ADDR_W-1:0] avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [btc_pkg::AV_DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic [btc_pkg::AV_DATA_W-1:0]     avs_readdata,
  output logic                              avs_waitrequest
);

  btc_pkg::btc_op_t             op;
  logic                         take;
  logic                         bit_val;
  logic                         skip;
  logic                         two_cycle;
  logic [btc_pkg::CTRL_W-1:0]   ctrl_r;
  logic                         exec_en;
  logic                         psa_wdog;
  logic                         last_skip_r;
  logic                         zero_shadow_r;
  logic                         to_n_shadow_r;
  logic                         pd_n_shadow_r;
  logic [btc_pkg::CNT_W-1:0]    skip_cnt_r;
  logic                         ack_r;
  logic                         hit_ctrl;
  logic                         hit_state;
  logic                         hit_skips;
  logic [btc_pkg::AV_DATA_W-1:0] rd_mux;

  assign exec_en  = ctrl_r[btc_pkg::CTRL_EXEC_EN];
  assign psa_wdog = ctrl_r[btc_pkg::CTRL_PSA_WDOG];

  btc_decode u_decode (
    .word (instr.word),
    .op   (op)
  );

  // a presented word counts only when ce and exec_en are high; discard is masked later per operation
  assign take    = ce && instr.valid && exec_en;
  assign bit_val = instr.fdata[op.bsel];

  always_comb begin
    skip = 1'b0;
    unique case (op.kind)
      btc_pkg::K_BT_CLEAR: skip = !bit_val;
      btc_pkg::K_BT_SET:   skip = bit_val;
      default:             skip = 1'b0;
    endcase
  end

  assign two_cycle = !discard && (skip || (op.kind == btc_pkg::K_CALL));

  btc_flow u_flow (
    .clock     (clock),
    .rst_n     (rst_n),
    .ce        (ce && exec_en),
    .take      (instr.valid),
    .two_cycle (two_cycle),
    .discard   (discard)
  );

  function automatic logic is_kind(input btc_pkg::btc_op_t o, input btc_pkg::btc_kind_t k,
                                   input logic go, input logic drop);
    is_kind = go && !drop && (o.kind == k);
  endfunction : is_kind

  // file register clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      file_we    <= 1'b0;
      file_waddr <= '0;
      file_wdata <= btc_pkg::ZERO_BYTE;
    end else if (ce) begin
      file_we <= is_kind(op, btc_pkg::K_CLEAR_FILE, take, discard);
      if (is_kind(op, btc_pkg::K_CLEAR_FILE, take, discard)) begin
        file_waddr <= op.faddr;
        file_wdata <= btc_pkg::ZERO_BYTE;
      end
    end
  end

  // accumulator clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_we    <= 1'b0;
      acc_wdata <= btc_pkg::ZERO_BYTE;
    end else if (ce) begin
      acc_we    <= is_kind(op, btc_pkg::K_CLEAR_ACC, take, discard);
      acc_wdata <= btc_pkg::ZERO_BYTE;
    end
  end

  // zero flag: only the two clears touch it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      zero_we  <= 1'b0;
      zero_val <= 1'b0;
    end else if (ce) begin
      zero_we  <= is_kind(op, btc_pkg::K_CLEAR_ACC, take, discard)
                || is_kind(op, btc_pkg::K_CLEAR_FILE, take, discard);
      zero_val <= 1'b1;
    end
  end

  // watchdog clear group
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      watchdog_counter_load  <= 1'b0;
      watchdog_counter_value <= btc_pkg::WDT_CLEAR;
      prescaler_clear        <= 1'b0;
      timeout_status_n_we    <= 1'b0;
      power_down_status_n_we <= 1'b0;
      status_n_val           <= 1'b0;
    end else if (ce) begin
      watchdog_counter_load  <= is_kind(op, btc_pkg::K_WDOG_CLEAR, take, discard);
      watchdog_counter_value <= btc_pkg::WDT_CLEAR;
      prescaler_clear        <= is_kind(op, btc_pkg::K_WDOG_CLEAR, take, discard)
                                && psa_wdog;
      timeout_status_n_we    <= is_kind(op, btc_pkg::K_WDOG_CLEAR, take, discard);
      power_down_status_n_we <= is_kind(op, btc_pkg::K_WDOG_CLEAR, take, discard);
      status_n_val           <= 1'b1;
    end
  end

  // subroutine call: push return address and load target
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pc_load    <= 1'b0;
      pc_target  <= '0;
      stack_push <= 1'b0;
      stack_data <= '0;
    end else if (ce) begin
      pc_load    <= is_kind(op, btc_pkg::K_CALL, take, discard);
      stack_push <= is_kind(op, btc_pkg::K_CALL, take, discard);
      if (is_kind(op, btc_pkg::K_CALL, take, discard)) begin
        stack_data <= instr.pc + btc_pkg::PC_STEP;
        pc_target  <= {instr.status[btc_pkg::STAT_PG_HI:btc_pkg::STAT_PG_LO],
                       1'b0, op.lit};
      end
    end
  end

  // no-op in place of the discarded prefetched word
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nop_exec <= 1'b0;
    end else if (ce) begin
      nop_exec <= take && discard;
    end
  end

  // observation shadows
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      last_skip_r <= 1'b0;
      skip_cnt_r  <= '0;
    end else if (ce && take && !discard && (op.kind == btc_pkg::K_BT_CLEAR
                                          || op.kind == btc_pkg::K_BT_SET)) begin
      last_skip_r <= skip;
      if (skip) skip_cnt_r <= skip_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      zero_shadow_r <= 1'b0;
      to_n_shadow_r <= 1'b0;
      pd_n_shadow_r <= 1'b0;
    end else if (ce) begin
      if (zero_we) zero_shadow_r <= zero_val;
      if (timeout_status_n_we) to_n_shadow_r <= status_n_val;
      if (power_down_status_n_we) pd_n_shadow_r <= status_n_val;
    end
  end

  // Avalon slave: one wait cycle, then answer
  assign hit_ctrl  = (avs_address == btc_pkg::OFS_CTRL);
  assign hit_state = (avs_address == btc_pkg::OFS_STATE);
  assign hit_skips = (avs_address == btc_pkg::OFS_SKIPS);
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux[btc_pkg::CTRL_W-1:0] = ctrl_r;
    end else if (hit_state) begin
      rd_mux[btc_pkg::ST_FLUSH]   = discard;
      rd_mux[btc_pkg::ST_LASTSKP] = last_skip_r;
      rd_mux[btc_pkg::ST_ZERO]    = zero_shadow_r;
      rd_mux[btc_pkg::ST_TO_N]    = to_n_shadow_r;
      rd_mux[btc_pkg::ST_PD_N]    = pd_n_shadow_r;
    end else if (hit_skips) begin
      rd_mux[btc_pkg::CNT_W-1:0]  = skip_cnt_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_r        <= 1'b0;
      avs_readdata <= '0;
    end else if (ce) begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (avs_read && !ack_r) avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r <= btc_pkg::CTRL_RESET;
    end else if (ce && avs_write && ack_r && hit_ctrl && avs_byteenable[0]) begin
      ctrl_r <= avs_writedata[btc_pkg::CTRL_W-1:0];
    end
  end

endmodule : btc_exec
`default_nettype wire

// ---- tb/btc_exec_assertions.sv ----
/*
  Concurrent checks on the execution block's instruction-side ports.
  Bound to every btc_exec instance; assumes ce drops only while no strobe is up.
*/
`timescale 1ns/1ns
`default_nettype none
module btc_exec_assertions (
  input wire logic                       clock,
  input wire logic                       rst_n,
  input wire logic                       ce,
  input wire btc_pkg::btc_instr_t        instr,
  input wire logic                       discard,
  input wire logic                       file_we,
  input wire logic [btc_pkg::FADDR_W-1:0] file_waddr,
  input wire logic [btc_pkg::DATA_W-1:0] file_wdata,
  input wire logic                       acc_we,
  input wire logic [btc_pkg::DATA_W-1:0] acc_wdata,
  input wire logic                       zero_we,
  input wire logic                       zero_val,
  input wire logic                       timeout_status_n_we,
  input wire logic                       power_down_status_n_we,
  input wire logic                       status_n_val,
  input wire logic                       pc_load,
  input wire logic [btc_pkg::PC_W-1:0]   pc_target,
  input wire logic                       stack_push,
  input wire logic [btc_pkg::PC_W-1:0]   stack_data,
  input wire logic                       nop_exec,
  input wire logic                       watchdog_counter_load,
  input wire logic [btc_pkg::WDT_W-1:0]  watchdog_counter_value,
  input wire logic                       prescaler_clear
);
  wire logic bit_v  = instr.fdata[instr.word[7:5]];
  wire logic is_clr = instr.word[11:8] == btc_pkg::OPC_BT_CLEAR;
  wire logic is_set = instr.word[11:8] == btc_pkg::OPC_BT_SET;
  wire logic go     = ce && instr.valid && !discard;
  wire logic cause  = instr.valid && ((is_clr && !bit_v) || (is_set && bit_v)
                      || instr.word[11:8] == btc_pkg::OPC_CALL);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_acc_clear: assert property (
    acc_we |-> acc_wdata == 8'h00 && zero_we && zero_val && !timeout_status_n_we
      && $past(instr.word) == btc_pkg::OPC_CLEAR_ACC) else $error("accumulator clear wrong");
  chk_file_clear: assert property (
    file_we |-> file_wdata == 8'h00 && file_waddr == $past(instr.word[4:0]) && zero_we
      && zero_val) else $error("file clear wrong");
  chk_call_target: assert property (
    pc_load |-> pc_target == {$past(instr.status[6:5]), 1'h0, $past(instr.word[7:0])})
    else $error("call target wrong");
  chk_call_push: assert property (
    stack_push |-> pc_load && stack_data == $past(instr.pc) + 11'h001)
    else $error("call return address wrong");
  chk_call_flush: assert property (pc_load |-> discard && !zero_we)
    else $error("call not two cycles");
  chk_skip_nop: assert property (
    discard && instr.valid && ce |=> nop_exec && !acc_we && !file_we && !pc_load && !zero_we)
    else $error("prefetched word not replaced by no-op");
  chk_skip_cause: assert property ($rose(discard) |-> $past(cause))
    else $error("flush without taken skip or call");
  chk_untaken_test: assert property (
    go && ((is_clr && bit_v) || (is_set && !bit_v)) |=> !discard && !zero_we && !nop_exec)
    else $error("untaken test had effects");
  chk_wdog_clear: assert property (
    watchdog_counter_load |-> watchdog_counter_value == 8'h00 && timeout_status_n_we
      && power_down_status_n_we && status_n_val && !zero_we) else $error("watchdog clear wrong");
  chk_psc_wdog: assert property (prescaler_clear |-> watchdog_counter_load)
    else $error("stray prescaler clear");

  cover property (nop_exec);
  cover property (pc_load);
  cover property (file_we);
  cover property (prescaler_clear);
endmodule : btc_exec_assertions

bind btc_exec btc_exec_assertions i_chk (.clock(clock), .rst_n(rst_n), .ce(ce),
  .instr(instr), .discard(discard), .file_we(file_we), .file_waddr(file_waddr),
  .file_wdata(file_wdata), .acc_we(acc_we), .acc_wdata(acc_wdata), .zero_we(zero_we),
  .zero_val(zero_val), .timeout_status_n_we(timeout_status_n_we),
  .power_down_status_n_we(power_down_status_n_we), .status_n_val(status_n_val),
  .pc_load(pc_load), .pc_target(pc_target), .stack_push(stack_push),
  .stack_data(stack_data), .nop_exec(nop_exec), .watchdog_counter_load(watchdog_counter_load),
  .watchdog_counter_value(watchdog_counter_value), .prescaler_clear(prescaler_clear));
`default_nettype wire

// ---- tb/bit_test_call_clear_execute_bench.sv ----
/*
  Self-checking bench: instruction sequences and Avalon-MM register accesses.
  Assumes the checker is attached by its own bind.
*/
`timescale 1ns/1ns
`default_nettype none
module bit_test_call_clear_execute_bench;
  logic clock, rst_n, ce, discard, file_we, acc_we, zero_we, zero_val, to_we, pd_we, sn_val;
  logic pc_load, stack_push, nop_exec, wd_load, psc_clr, avs_read, avs_write, avs_wait;
  logic [4:0]  file_waddr;
  logic [7:0]  file_wdata, acc_wdata, wd_val;
  logic [10:0] pc_target, stack_data;
  logic [3:0]  avs_address, avs_be;
  logic [31:0] avs_wdata, avs_rdata, rd;
  btc_pkg::btc_instr_t instr;
  int fail_count, n_compared;
  // file, acc, zero, timeout, power-down, pc, push, nop, watchdog, prescaler
  wire logic [9:0] pulses = {file_we, acc_we, zero_we, to_we, pd_we, pc_load, stack_push,
                             nop_exec, wd_load, psc_clr};

  btc_exec i_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .instr(instr), .discard(discard),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .zero_we(zero_we), .zero_val(zero_val),
    .timeout_status_n_we(to_we), .power_down_status_n_we(pd_we), .status_n_val(sn_val),
    .pc_load(pc_load), .pc_target(pc_target), .stack_push(stack_push),
    .stack_data(stack_data), .nop_exec(nop_exec), .watchdog_counter_load(wd_load),
    .watchdog_counter_value(wd_val), .prescaler_clear(psc_clr), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_wdata),
    .avs_byteenable(avs_be), .avs_readdata(avs_rdata), .avs_waitrequest(avs_wait));

  always #5 clock = ~clock;

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // entered and left just after a rising edge; waitrequest sampled on rising edges
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_wdata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_wait !== 1'h0 && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
    rd = avs_rdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clock);
  endtask : av

  task automatic put(input logic [11:0] w, input logic [7:0] f, input logic [10:0] p,
                     input logic [7:0] s);
    instr <= '{1'h1, w, p, f, s};
    @(posedge clock);
  endtask : put

  task automatic one(input logic [11:0] w, input logic [9:0] e);
    put(w, 8'hFF, 11'h020, 8'h00);
    instr.valid <= 1'h0;
    @(negedge clock);
    cmp(pulses, e);
    @(posedge clock);
  endtask : one

  // word, then a clear-accumulator word right behind it
  task automatic seq2(input logic [11:0] w, input logic [7:0] f, input logic [10:0] p,
                      input logic [7:0] s, input logic [9:0] e1, input logic dsc,
                      input logic [9:0] e2);
    put(w, f, p, s);
    instr <= '{1'h1, btc_pkg::OPC_CLEAR_ACC, p + 11'h001, 8'h00, 8'h00};
    @(negedge clock);
    cmp(discard, dsc);
    cmp(pulses, e1);
    @(posedge clock);
    instr.valid <= 1'h0;
    @(negedge clock);
    cmp(pulses, e2);
    @(posedge clock);
  endtask : seq2

  initial begin
    logic [7:0] fd;
    logic       tk;
    clock = 1'h0;
    rst_n = 1'h0;
    ce = 1'h1;
    instr = '0;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_wdata = 32'h0;
    avs_be = 4'hF;
    fail_count = 0;
    n_compared = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    av(1'h0, 4'h0, 32'h0);
    cmp(rd, 32'h3);
    av(1'h0, 4'h4, 32'h0);
    cmp(rd, 32'h0);
    av(1'h0, 4'hC, 32'h0);
    cmp(rd, 32'h0);
    av(1'h1, 4'hC, 32'hFFFFFFFF);
    av(1'h0, 4'h0, 32'h0);
    cmp(rd, 32'h3);
    one(btc_pkg::OPC_CLEAR_ACC, 10'h180);
    cmp(acc_wdata, 32'h0);
    for (int a = 0; a < 32; a += 31) begin
      one({btc_pkg::OPC_CLEAR_FILE, a[4:0]}, 10'h280);
      cmp(file_waddr, a[4:0]);
    end
    for (int b = 0; b < 8; b++) begin
      for (int k = 0; k < 4; k++) begin
        fd = k[1] ? (8'h01 << b) : ~(8'h01 << b);
        tk = k[0] == k[1];
        seq2({k[0] ? btc_pkg::OPC_BT_SET : btc_pkg::OPC_BT_CLEAR, b[2:0], 5'h0A}, fd,
             11'h010, 8'h00, 10'h000, tk, tk ? 10'h004 : 10'h180);
      end
    end
    av(1'h0, 4'h8, 32'h0);
    cmp(rd, 32'h10);
    seq2({btc_pkg::OPC_CALL, 8'hA5}, 8'h00, 11'h2AB, 8'h60, 10'h018, 1'h1, 10'h004);
    cmp({pc_target, stack_data}, {11'h6A5, 11'h2AC});
    seq2({btc_pkg::OPC_CALL, 8'h5A}, 8'h00, 11'h7FF, 8'h9F, 10'h018, 1'h1, 10'h004);
    cmp({pc_target, stack_data}, {11'h05A, 11'h000});
    one(btc_pkg::OPC_WDOG_CLEAR, 10'h063);
    cmp({wd_val, sn_val}, {8'h00, 1'h1});
    av(1'h0, 4'h4, 32'h0);
    cmp(rd, 32'h1E);
    av(1'h1, 4'h0, 32'h2);
    one(btc_pkg::OPC_WDOG_CLEAR, 10'h062);
    av(1'h1, 4'h0, 32'h1);
    one(btc_pkg::OPC_CLEAR_ACC, 10'h000);
    av(1'h1, 4'h0, 32'h3);
    // clock enable low: a presented word must leave no trace
    ce <= 1'h0;
    one(btc_pkg::OPC_CLEAR_ACC, 10'h000);
    ce <= 1'h1;
    final_report();
  end
endmodule : bit_test_call_clear_execute_bench
`default_nettype wire
